/* logic/bcd_pkg.sv */
// Package for the bridge control and diagnostic register bank.
// Assumes a configuration-space port with byte offsets and byte enables.
package bcd_pkg;
   // Byte offset of the link timer register.
   localparam logic [7:0] BCD_LINK_TIMER_OFS = 8'hC4;
   // Byte offset of the upstream buffer register, which sits just before it.
   localparam logic [7:0] BCD_UP_BUF_OFS = 8'hC0;
   // Reset value of the link timer register.
   localparam logic [31:0] BCD_LINK_TIMER_RST = 32'h00120108;
   // Writable bits of the link timer register.
   localparam logic [31:0] BCD_LINK_TIMER_WMASK = 32'h001FFFFF;
   // Reset value of the upstream buffer register.
   localparam logic [31:0] BCD_UP_BUF_RST = 32'h00000000;
   // Writable bits of the upstream buffer register; bit 0 is read-only zero.
   localparam logic [31:0] BCD_UP_BUF_WMASK = 32'h0000FFFE;
   // Field positions in the link timer register.
   localparam int BCD_L1_SEP_LSB = 18;
   localparam int BCD_L1_SHR_LSB = 15;
   localparam int BCD_SEC_MASK_BIT = 10;
   localparam int BCD_L1_ASPM_LSB = 6;
   localparam int BCD_L0S_LSB = 2;
   // Field positions in the upstream buffer register.
   localparam int BCD_THR_VAL_LSB = 4;
   localparam int BCD_THR_EN_BIT = 3;
   localparam int BCD_MMCFG_BIT = 2;
   // Timer unit figures.
   localparam int BCD_L1_ASPM_UNIT_NS = 512;
   localparam int BCD_CLK_PERIOD_NS = 8;
   // One L1 ASPM tick in system clocks (512 ns at 8 ns).
   localparam int BCD_L1_ASPM_UNIT_CYC = BCD_L1_ASPM_UNIT_NS / BCD_CLK_PERIOD_NS;
   // Cache line quantity used when the programmed size is invalid, in dwords.
   localparam logic [7:0] BCD_DEFAULT_LINE_DW = 8'h08;
   // Extra dwords added per threshold code.
   localparam logic [7:0] BCD_EXTRA_4DW = 8'h04;
   localparam logic [7:0] BCD_EXTRA_8DW = 8'h08;
   localparam logic [7:0] BCD_EXTRA_12DW = 8'h0C;

   // Configuration access request.
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] offset;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } bcd_cfg_req_t;

   // Decoded controls driven to the rest of the bridge.
   typedef struct packed {
      logic [2:0] link_cap_l1_exit_latency;
      logic [3:0] l1_aspm_entry_delay;
      logic [3:0] l0s_entry_delay;
      logic mmcfg_access_en;
      logic secondary_reset_out;
   } bcd_ctrl_t;
endpackage

/* logic/bcd_threshold.sv */
// Upstream request-response buffer threshold calculator.
// Assumes the cache line size and free space arrive in dwords.
`timescale 1ns/1ps
module bcd_threshold import bcd_pkg::*; #(
   parameter int DW_W = 8
) (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // Settings.
   input wire logic thr_en_i,
   input wire logic [1:0] thr_code_i,
   input wire logic [7:0] line_dw_i,
   input wire logic line_valid_i,
   // Buffer state.
   input wire logic [DW_W-1:0] free_dw_i,
   // Decision.
   output logic accept_o
);
   // Effective cache line and required space.
   logic [7:0] line_dw;
   logic [9:0] need_dw;
   logic accept_reg;
   logic accept_next;

   // Work out the space needed and compare against what is free.
   always_comb begin
      line_dw = line_valid_i ? line_dw_i : BCD_DEFAULT_LINE_DW;
      unique case (thr_code_i)
         2'h0: need_dw = {2'h0, line_dw} + {2'h0, BCD_EXTRA_4DW};
         2'h1: need_dw = {2'h0, line_dw} + {2'h0, BCD_EXTRA_8DW};
         2'h2: need_dw = {2'h0, line_dw} + {2'h0, BCD_EXTRA_12DW};
         2'h3: need_dw = {1'h0, line_dw, 1'h0} + {2'h0, BCD_EXTRA_4DW};
      endcase
      if (!thr_en_i) begin
         accept_next = 1'b1;
      end else begin
         accept_next = (32'(free_dw_i) >= 32'(need_dw));
      end
   end

   // Register the decision so the output comes from a flip-flop.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         accept_reg <= 1'b1;
      end else begin
         accept_reg <= accept_next;
      end
   end

   assign accept_o = accept_reg;
endmodule

/* logic/bcd_regs.sv */
// Control and diagnostic register bank of the bridge configuration space.
// Assumes a one-cycle configuration port; read data is registered.
// Notes on behaviour
// - Accept upstream only with threshold space free.
// - Threshold codes: line plus 4/8/12, two lines+4.
// - Invalid line size counts as 8 DW.
// - Threshold mode bit, off at reset.
// - Bit 2 opens memory-mapped configuration access.
// - Read-only reserved bits always read zero.
// - Shared clock set mirrors separate-clock latency.
// - Shared clock clear mirrors shared-clock latency.
// - Mask bit suppresses secondary bus reset.
// - L1 ASPM delay in 512 ns, reset 0100b.
// - L0s delay in 62.5 MHz ticks, reset 0010b.
// - Fundamental, global or power-on reset restores defaults.
// - Register at C4h, reset 0012 0108h.
`timescale 1ns/1ps
module bcd_regs import bcd_pkg::*; #(
   parameter int DW_W = 8
) (
   // Clock and resets.
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic fund_rstn_i,
   input wire logic global_reset_in_i,
   input wire logic por_rstn_i,
   // Configuration port.
   input wire bcd_cfg_req_t cfg_req_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_ack_o,
   // Link and bridge inputs.
   input wire logic shared_clock_config_i,
   input wire logic secondary_reset_request_i,
   input wire logic [7:0] cache_line_dw_i,
   input wire logic cache_line_valid_i,
   input wire logic [DW_W-1:0] up_buf_free_dw_i,
   // Controls out.
   output bcd_ctrl_t ctrl_o,
   output logic up_accept_o
);
   // Stored register images.
   logic [31:0] link_timer_diag_control_reg;
   logic [31:0] link_timer_diag_control_next;
   logic [31:0] upstream_buffer_diag_control_reg;
   logic [31:0] upstream_buffer_diag_control_next;
   // Read path.
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic ack_reg;
   logic ack_next;
   // Output control image.
   bcd_ctrl_t ctrl_reg;
   bcd_ctrl_t ctrl_next;
   // Combined reset.
   logic any_rst;
   // Byte lane write mask.
   logic [31:0] lane_mask;

   assign any_rst = !rstn_i || !fund_rstn_i || global_reset_in_i || !por_rstn_i;

   // Expand byte enables into a bit mask; one generate per lane.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign lane_mask[g*8 +: 8] = {8{cfg_req_i.byte_en[g]}};
      end
   endgenerate

   // Next-state of the registers and the read path.
   always_comb begin
      link_timer_diag_control_next = link_timer_diag_control_reg;
      upstream_buffer_diag_control_next = upstream_buffer_diag_control_reg;
      rdata_next = 32'h00000000;
      ack_next = cfg_req_i.valid;
      if (cfg_req_i.valid && cfg_req_i.write) begin
         if (cfg_req_i.offset == BCD_LINK_TIMER_OFS) begin
            link_timer_diag_control_next = (link_timer_diag_control_reg & ~(lane_mask & BCD_LINK_TIMER_WMASK))
               | (cfg_req_i.wdata & lane_mask & BCD_LINK_TIMER_WMASK);
         end else if (cfg_req_i.offset == BCD_UP_BUF_OFS) begin
            upstream_buffer_diag_control_next = (upstream_buffer_diag_control_reg
               & ~(lane_mask & BCD_UP_BUF_WMASK)) | (cfg_req_i.wdata & lane_mask & BCD_UP_BUF_WMASK);
         end
      end else if (cfg_req_i.valid) begin
         // Unmapped offsets read as zero.
         if (cfg_req_i.offset == BCD_LINK_TIMER_OFS) begin
            rdata_next = link_timer_diag_control_reg;
         end else if (cfg_req_i.offset == BCD_UP_BUF_OFS) begin
            rdata_next = upstream_buffer_diag_control_reg;
         end
      end
   end

   // Decode the stored fields into the controls the bridge uses.
   always_comb begin
      ctrl_next.link_cap_l1_exit_latency = shared_clock_config_i
         ? link_timer_diag_control_reg[BCD_L1_SEP_LSB +: 3]
         : link_timer_diag_control_reg[BCD_L1_SHR_LSB +: 3];
      ctrl_next.l1_aspm_entry_delay = link_timer_diag_control_reg[BCD_L1_ASPM_LSB +: 4];
      ctrl_next.l0s_entry_delay = link_timer_diag_control_reg[BCD_L0S_LSB +: 4];
      ctrl_next.mmcfg_access_en = upstream_buffer_diag_control_reg[BCD_MMCFG_BIT];
      ctrl_next.secondary_reset_out = secondary_reset_request_i
         && !link_timer_diag_control_reg[BCD_SEC_MASK_BIT];
   end

   // Register everything; any reset source brings back the defaults.
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         link_timer_diag_control_reg <= BCD_LINK_TIMER_RST;
         upstream_buffer_diag_control_reg <= BCD_UP_BUF_RST;
         rdata_reg <= 32'h00000000;
         ack_reg <= 1'b0;
         ctrl_reg <= '0;
      end else begin
         link_timer_diag_control_reg <= link_timer_diag_control_next;
         upstream_buffer_diag_control_reg <= upstream_buffer_diag_control_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         ctrl_reg <= ctrl_next;
      end
   end

   bcd_threshold #(
      .DW_W(DW_W)
   ) u_thr (
      .sys_clk_i(sys_clk_i),
      .rstn_i(!any_rst),
      .thr_en_i(upstream_buffer_diag_control_reg[BCD_THR_EN_BIT]),
      .thr_code_i(upstream_buffer_diag_control_reg[BCD_THR_VAL_LSB +: 2]),
      .line_dw_i(cache_line_dw_i),
      .line_valid_i(cache_line_valid_i),
      .free_dw_i(up_buf_free_dw_i),
      .accept_o(up_accept_o)
   );

   assign cfg_rdata_o = rdata_reg;
   assign cfg_ack_o = ack_reg;
   assign ctrl_o = ctrl_reg;
endmodule

/* sim/bcd_regs_properties.sv */
// Port checker for the control and diagnostic register bank.
// Assumes the one-cycle configuration port; bound to every bank instance.
`timescale 1ns/1ps
module bcd_regs_check import bcd_pkg::*; #(
   parameter int DW_W = 8
) (
   // Clock and resets.
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic fund_rstn_i,
   input wire logic global_reset_in_i,
   input wire logic por_rstn_i,
   // Configuration port.
   input wire bcd_cfg_req_t cfg_req_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic cfg_ack_o,
   // Link, bridge and control signals.
   input wire logic shared_clock_config_i,
   input wire logic secondary_reset_request_i,
   input wire logic [7:0] cache_line_dw_i,
   input wire logic cache_line_valid_i,
   input wire logic [DW_W-1:0] up_buf_free_dw_i,
   input wire bcd_ctrl_t ctrl_o,
   input wire logic up_accept_o
);
   // Any one of the four sources holds the bank in reset.
   wire rst_any = !rstn_i || !fund_rstn_i || global_reset_in_i || !por_rstn_i;
   bcd_cfg_req_t req_reg;
   logic shr_reg;
   logic secondary_reset_request_reg;
   // Request and inputs seen at the edge that launched the answer now visible.
   always_ff @(posedge sys_clk_i) begin
      req_reg <= cfg_req_i;
      shr_reg <= shared_clock_config_i;
      secondary_reset_request_reg <= secondary_reset_request_i;
   end
   wire rd4 = cfg_ack_o && !req_reg.write && req_reg.offset == BCD_LINK_TIMER_OFS;
   wire rd0 = cfg_ack_o && !req_reg.write && req_reg.offset == BCD_UP_BUF_OFS;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_any);
   a_ack_follows: assert property (cfg_req_i.valid |=> cfg_ack_o) else $error("ack missing");
   a_ack_no_spur: assert property (!cfg_req_i.valid |=> !cfg_ack_o) else $error("stray ack");
   a_lat_sep: assert property (rd4 && shr_reg |-> ctrl_o.link_cap_l1_exit_latency == cfg_rdata_o[20:18])
      else $error("latency not from separate field");
   a_lat_shr: assert property (rd4 && !shr_reg |-> ctrl_o.link_cap_l1_exit_latency == cfg_rdata_o[17:15])
      else $error("latency not from shared field");
   a_timer_fields: assert property (rd4 |-> {ctrl_o.l1_aspm_entry_delay, ctrl_o.l0s_entry_delay} == cfg_rdata_o[9:2])
      else $error("timer fields differ");
   a_c4_rsvd: assert property (rd4 |-> cfg_rdata_o[31:21] == 11'h000) else $error("reserved bits set");
   a_c0_rsvd: assert property (rd0 |-> cfg_rdata_o[0] == 1'h0) else $error("bit 0 set");
   a_mmcfg_bit: assert property (rd0 |-> ctrl_o.mmcfg_access_en == cfg_rdata_o[2]) else $error("mmcfg differs");
   a_secondary_reset_request_mask: assert property (rd4 |-> ctrl_o.secondary_reset_out == (secondary_reset_request_reg && !cfg_rdata_o[10]))
      else $error("reset mask wrong");
   a_thr_off: assert property (rd0 && !cfg_rdata_o[3] |-> up_accept_o) else $error("accept low with mode off");
   c_shared_read: cover property (rd4 && shr_reg);
   c_thr_on: cover property (rd0 && cfg_rdata_o[3]);
   c_secondary_reset_request_out: cover property (ctrl_o.secondary_reset_out);
endmodule
bind bcd_regs bcd_regs_check #(.DW_W(DW_W)) u_bcd_regs_check (.sys_clk_i, .rstn_i, .fund_rstn_i,
   .global_reset_in_i, .por_rstn_i, .cfg_req_i, .cfg_rdata_o, .cfg_ack_o, .shared_clock_config_i,
   .secondary_reset_request_i, .cache_line_dw_i, .cache_line_valid_i, .up_buf_free_dw_i, .ctrl_o, .up_accept_o);

/* sim/bcd_regs_tb.sv */
// Self-checking testbench for the control and diagnostic register bank.
// Assumes the bank answers each access one cycle later and controls settle a cycle after.
`timescale 1ns/1ps
module bcd_regs_tb import bcd_pkg::*;;
   logic sys_clk_i = 0, rstn_i = 0, fund_rstn_i = 1, global_reset_in_i = 0, por_rstn_i = 1;
   bcd_cfg_req_t cfg_req_i = '0;
   logic shared_clock_config_i = 0, secondary_reset_request_i = 0, cache_line_valid_i = 1;
   logic [7:0] cache_line_dw_i = 8'h10, up_buf_free_dw_i = 8'h00;
   logic [31:0] cfg_rdata_o, q;
   logic cfg_ack_o, up_accept_o;
   bcd_ctrl_t ctrl_o;
   int n_mismatch = 0, num_checks = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   bcd_regs #(.DW_W(8)) u_bcd_regs (.sys_clk_i, .rstn_i, .fund_rstn_i, .global_reset_in_i, .por_rstn_i,
      .cfg_req_i, .cfg_rdata_o, .cfg_ack_o, .shared_clock_config_i, .secondary_reset_request_i,
      .cache_line_dw_i, .cache_line_valid_i, .up_buf_free_dw_i, .ctrl_o, .up_accept_o);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
      end
   endtask
   // One access; the read data lands in q. The read also gives controls time to settle.
   task acc(input logic w, input logic [7:0] o, input logic [31:0] d);
      @(posedge sys_clk_i);
      cfg_req_i <= '{1'h1, w, o, 4'hF, d};
      @(posedge sys_clk_i);
      cfg_req_i.valid <= 1'h0;
      #1 q = cfg_rdata_o;
      chk({31'h0, cfg_ack_o}, 32'h1);
   endtask
   task t_defaults;
      acc(0, BCD_LINK_TIMER_OFS, 0);
      chk(q, 32'h00120108);
      acc(0, BCD_UP_BUF_OFS, 0);
      chk(q, 32'h0);
      chk({19'h0, ctrl_o}, {19'h0, 3'h4, 4'h4, 4'h2, 2'h0});
      chk({31'h0, up_accept_o}, 32'h1);
      acc(0, 8'h80, 0);
      chk(q, 32'h0);
   endtask
   task t_link;
      // Reserved writable bits 14:11 and 1:0 are written as zero; read-only bits as ones.
      acc(1, BCD_LINK_TIMER_OFS, 32'hFFFF87FC);
      acc(0, BCD_LINK_TIMER_OFS, 0);
      chk(q, 32'h001F87FC);
      acc(1, BCD_LINK_TIMER_OFS, 32'h000A8258);
      shared_clock_config_i <= 1'h1;
      acc(0, BCD_LINK_TIMER_OFS, 0);
      chk({29'h0, ctrl_o.link_cap_l1_exit_latency}, 32'h2);
      chk({24'h0, ctrl_o.l1_aspm_entry_delay, ctrl_o.l0s_entry_delay}, 32'h96);
      shared_clock_config_i <= 1'h0;
      secondary_reset_request_i <= 1'h1;
      acc(0, BCD_LINK_TIMER_OFS, 0);
      chk({29'h0, ctrl_o.link_cap_l1_exit_latency}, 32'h5);
      chk({31'h0, ctrl_o.secondary_reset_out}, 32'h1);
      acc(1, BCD_LINK_TIMER_OFS, 32'h00000400);
      acc(0, BCD_LINK_TIMER_OFS, 0);
      chk({31'h0, ctrl_o.secondary_reset_out}, 32'h0);
      secondary_reset_request_i <= 1'h0;
   endtask
   // Free space exactly at the need is accepted, one dword short is not.
   task t_thresh;
      int need;
      acc(1, BCD_UP_BUF_OFS, 32'h4);
      acc(0, BCD_UP_BUF_OFS, 0);
      chk({31'h0, ctrl_o.mmcfg_access_en}, 32'h1);
      for (int c = 0; c < 5; c++) begin
         need = (c == 4) ? 12 : (c == 3) ? 36 : 16 + 4 * (c + 1);
         cache_line_valid_i <= (c != 4);
         acc(1, BCD_UP_BUF_OFS, 32'h8 | ((c % 4) << 4));
         up_buf_free_dw_i <= 8'(need);
         acc(0, BCD_UP_BUF_OFS, 0);
         chk({31'h0, up_accept_o}, 32'h1);
         up_buf_free_dw_i <= 8'(need - 1);
         acc(0, BCD_UP_BUF_OFS, 0);
         chk({31'h0, up_accept_o}, 32'h0);
      end
      acc(1, BCD_UP_BUF_OFS, 32'h30);
      acc(0, BCD_UP_BUF_OFS, 0);
      chk({31'h0, up_accept_o}, 32'h1);
      cache_line_valid_i <= 1'h1;
   endtask
   // Each of the other three reset sources alone restores the default.
   task t_resets;
      for (int i = 0; i < 3; i++) begin
         acc(1, BCD_LINK_TIMER_OFS, 32'h0);
         fund_rstn_i <= (i != 0);
         global_reset_in_i <= (i == 1);
         por_rstn_i <= (i != 2);
         @(posedge sys_clk_i);
         fund_rstn_i <= 1'h1;
         global_reset_in_i <= 1'h0;
         por_rstn_i <= 1'h1;
         acc(0, BCD_LINK_TIMER_OFS, 0);
         chk(q, 32'h00120108);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_i);
      rstn_i <= 1'h1;
      t_defaults;
      t_link;
      t_thresh;
      t_resets;
      summarize;
   end
   // The tests need well under a thousand cycles; a hang ends here.
   initial begin
      #100000;
      n_mismatch++;
      summarize;
   end
endmodule
